/* line_interface_circuit_pkg.sv */
package line_interface_circuit_pkg;

   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned BIT_PERIOD_NS = 488;
   // The serial bit rate may not be exceeded, so the divider rounds up.
   localparam int unsigned BIT_DIV       = (BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0]  BIT_DIV_LAST  = 5'(BIT_DIV - 1);
   localparam logic [2:0]  LAST_BIT      = 3'h7;

   localparam logic [7:0]  OFF_CTRL      = 8'h00;
   localparam logic [7:0]  OFF_CMD       = 8'h04;
   localparam logic [7:0]  OFF_STAT      = 8'h08;

   localparam logic [7:0]  SER_PDOWN     = 8'h00;
   localparam logic [7:0]  SER_PUP_BASE  = 8'h80;
   localparam logic [7:0]  SER_PUP_MASK  = 8'hFC;
   localparam logic [7:0]  SER_ACTIVE    = 8'hC0;
   localparam logic [7:0]  SER_RING      = 8'hA0;
   localparam logic [7:0]  SER_ON        = 8'h40;
   localparam logic [7:0]  SER_OFF       = 8'hC0;
   localparam logic [7:0]  SER_GK        = 8'h80;
   localparam logic [7:0]  P1_PDOWN      = 8'h00;
   localparam logic [7:0]  P1_ACTIVE     = 8'h80;
   localparam logic [7:0]  P1_RING       = 8'hE0;
   localparam logic [7:0]  P1_ON         = 8'h80;
   localparam logic [7:0]  P1_OFF        = 8'h00;
   localparam logic [7:0]  P1_GK         = 8'h40;
   localparam logic [7:0]  P2_PDOWN      = 8'h00;
   localparam logic [7:0]  P2_ACTIVE     = 8'h11;
   localparam logic [7:0]  P2_RING       = 8'h77;
   localparam logic [7:0]  P2_ON         = 8'h11;
   localparam logic [7:0]  P2_OFF        = 8'h00;
   localparam logic [7:0]  P2_GK         = 8'h22;
   localparam logic [7:0]  MB_STANDBY    = 8'h03;
   localparam logic [7:0]  MB_ACTIVE     = 8'h07;
   localparam logic [7:0]  MB_RING       = 8'h4F;
   localparam logic [7:0]  MB_CHB        = 8'h80;
   localparam logic [7:0]  MB_ON         = 8'h01;
   localparam logic [7:0]  MB_OFF        = 8'h03;
   localparam logic [7:0]  MB_GK         = 8'h4B;
   localparam logic [1:0]  ILIM_RST      = 2'h0;

   typedef enum logic [1:0] {
      IFM_SERIAL = 2'b00,
      IFM_PAR1   = 2'b01,
      IFM_PAR2   = 2'b10,
      IFM_MODULE = 2'b11
   } ifm_t;

   typedef enum logic [1:0] {
      LM_PDOWN   = 2'b00,
      LM_STANDBY = 2'b01,
      LM_ACTIVE  = 2'b11,
      LM_RING    = 2'b10
   } lmode_t;

   typedef struct packed {
      logic       hit;
      logic       chan;
      lmode_t     mode;
      logic       set_ilim;
      logic [1:0] ilim;
   } dec_t;

   typedef struct packed {
      logic ext_clk;
      logic line_interface_circuit_sel;
      ifm_t ifm;
   } ctrl_t;

   localparam ctrl_t CTRL_RST = '{ext_clk: 1'b0, line_interface_circuit_sel: 1'b0, ifm: IFM_SERIAL};

   typedef struct packed {
      logic       chan;
      logic [7:0] code;
   } cmd_t;

   typedef struct packed {
      logic [7:0] sts_b;
      logic [7:0] sts_a;
      logic [1:0] gk;
      logic [1:0] off;
      lmode_t     mode_b;
      lmode_t     mode_a;
   } stat_t;

endpackage

/* dec_if.sv */
interface dec_if import line_interface_circuit_pkg::*; ();
   dec_t dec;
   logic valid;
   modport src (output dec, output valid);
   modport dst (input dec, input valid);
endinterface

/* sig_shifter.sv */
module sig_shifter import line_interface_circuit_pkg::*; (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       enable,
   input  wire logic       frame_sync,
   input  wire logic       cs,
   input  wire logic       bit_en,
   input  wire logic       sdi,
   input  wire logic [7:0] tx_byte,
   output logic [7:0]      rx_byte,
   output logic            rx_valid,
   output logic            sdo
);
   typedef enum logic [1:0] {SH_IDLE = 2'b00, SH_SHIFT = 2'b01, SH_DONE = 2'b11} sh_state_t;

   typedef struct packed {
      sh_state_t  state;
      logic [2:0] cnt;
      logic [7:0] sh;
      logic [7:0] rx;
      logic       valid;
   } st_t;

   st_t s;
   st_t n;

   always_comb begin
      n = s;
      n.valid = 1'b0;
      case (s.state)
         SH_IDLE: begin
            if (enable && cs) begin
               n.state = SH_SHIFT;
               n.cnt = '0;
               n.sh = tx_byte;
            end
         end
         SH_SHIFT: begin
            // A frame start or a dropped select discards a partial byte.
            if (!enable || !cs || frame_sync) begin
               n.state = SH_IDLE;
            end else if (bit_en) begin
               n.sh = {s.sh[6:0], sdi};
               n.cnt = s.cnt + 3'h1;
               if (s.cnt == LAST_BIT) begin
                  n.state = SH_DONE;
                  n.rx = {s.sh[6:0], sdi};
                  n.valid = 1'b1;
               end
            end
         end
         SH_DONE: begin
            if (!cs) begin
               n.state = SH_IDLE;
            end
         end
         default: n.state = SH_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{state: SH_IDLE, cnt: 3'h0, sh: 8'h00, rx: 8'h00, valid: 1'b0};
      end else begin
         s <= n;
      end
   end

   assign rx_byte  = s.rx;
   assign rx_valid = s.valid;
   assign sdo      = s.sh[7];

endmodule // sig_shifter

/* mode_decoder.sv */
module mode_decoder import line_interface_circuit_pkg::*; (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire ifm_t       ifm,
   input  wire logic [7:0] code,
   input  wire logic       chan,
   input  wire logic       valid,
   dec_if.src              dout
);
   typedef struct packed {
      logic valid;
      dec_t dec;
   } st_t;

   st_t s;
   st_t n;

   function automatic dec_t decode(ifm_t m, logic [7:0] c, logic ch);
      dec_t d;
      logic [7:0] base;
      d = '{hit: 1'b1, chan: ch, mode: LM_PDOWN, set_ilim: 1'b0, ilim: ILIM_RST};
      base = c & ~MB_CHB;
      case (m)
         IFM_SERIAL: begin
            // RULE_01 power down code
            if (c == SER_PDOWN) begin
               d.mode = LM_PDOWN;
            // RULE_02 power up current
            end else if ((c & SER_PUP_MASK) == SER_PUP_BASE) begin
               d.mode = LM_STANDBY;
               d.set_ilim = 1'b1;
               d.ilim = c[1:0];
            // RULE_03 conversation and ringing
            end else if (c == SER_ACTIVE) begin
               d.mode = LM_ACTIVE;
            end else if (c == SER_RING) begin
               d.mode = LM_RING;
            end else begin
               d.hit = 1'b0;
            end
         end
         // RULE_09 first variant codes
         IFM_PAR1: begin
            if (c == P1_PDOWN) d.mode = LM_PDOWN;
            else if (c == P1_ACTIVE) d.mode = LM_ACTIVE;
            else if (c == P1_RING) d.mode = LM_RING;
            else d.hit = 1'b0;
         end
         // RULE_11 second variant codes
         IFM_PAR2: begin
            if (c == P2_PDOWN) d.mode = LM_PDOWN;
            else if (c == P2_ACTIVE) d.mode = LM_ACTIVE;
            else if (c == P2_RING) d.mode = LM_RING;
            else d.hit = 1'b0;
         end
         IFM_MODULE: begin
            // RULE_14 channel B offset
            d.chan = (c & MB_CHB) != 8'h00;
            // RULE_13 module board codes
            if (base == MB_STANDBY) d.mode = LM_STANDBY;
            else if (base == MB_ACTIVE) d.mode = LM_ACTIVE;
            else if (base == MB_RING) d.mode = LM_RING;
            else d.hit = 1'b0;
         end
         default: d.hit = 1'b0;
      endcase
      return d;
   endfunction

   always_comb begin
      n.valid = valid;
      n.dec = decode(ifm, code, chan);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign dout.valid = s.valid;
   assign dout.dec   = s.dec;

endmodule // mode_decoder

/* line_interface_circuit_mode_signaling_decoder.sv */
// How it works
// RULE_01: Serial byte 00 powers the circuit down.
// RULE_02: Serial 80..83 power up, set loop current.
// RULE_03: Serial C0 conversation, A0 ringing.
// RULE_04: Serial status 40 on, C0 off, 80 ground.
// RULE_05: Controller strobe drives the circuit chip select.
// RULE_06: Controller picks circuit A or B by strobe; here the CTRL select bit picks it and the strobe only drives chip select.
// RULE_07: Circuit B takes bytes from serial line one.
// RULE_08: Serial commands arrive in the port signaling byte.
// RULE_09: First variant: 00 down, 80 talk, E0 ring.
// RULE_10: First variant status 80 on, 00, 40.
// RULE_11: Second variant: 00 down, 11 talk, 77 ring.
// RULE_12: Second variant status 11 on, 00, 22.
// RULE_13: Module board: 03 standby, 07 talk, 4F ring.
// RULE_14: Channel B codes are channel A plus 80.
// RULE_15: Module board status 03 off, 4B ground.
// RULE_16: Module board runs in parallel mode only.
// RULE_17: Configuration picks circuit and internal or external clock.
// RULE_18: Unknown codes leave the circuit mode unchanged.
module line_interface_circuit_mode_signaling_decoder import line_interface_circuit_pkg::*; (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        frame_sync,
   input  wire logic        signaling_strobe_pin,
   input  wire logic        ext_data_clk,
   input  wire logic        serial_in,
   output logic             serial_out,
   output logic             line_cs_n,
   input  wire logic [1:0]  off_hook,
   input  wire logic [1:0]  ground_key,
   output logic [1:0]       pdown,
   output logic [1:0]       ring,
   output logic [1:0]       active,
   output logic [1:0][1:0]  ilim
);
   typedef struct packed {
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
      ctrl_t            ctrl;
      cmd_t             cmd;
      logic             cmd_go;
      logic [4:0]       div;
      logic             clk_q;
      logic             cs_n;
      lmode_t [1:0]     mode;
      logic [1:0][1:0]  ilim;
      logic [1:0][7:0]  sts;
      logic [1:0]       pdown;
      logic [1:0]       ring;
      logic [1:0]       active;
   } st_t;

   localparam st_t ST_RST = '{
      pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000, ctrl: CTRL_RST,
      cmd: '0, cmd_go: 1'b0, div: 5'h00, clk_q: 1'b0, cs_n: 1'b1,
      mode: {LM_PDOWN, LM_PDOWN}, ilim: {ILIM_RST, ILIM_RST}, sts: '0,
      pdown: 2'b11, ring: 2'b00, active: 2'b00};

   st_t          s;
   st_t          n;
   logic         ser;
   logic         setup;
   logic         wr_fire;
   logic         bit_en;
   logic [7:0]   rx_byte;
   logic         rx_valid;
   logic [7:0]   dec_code;
   logic         dec_chan;
   logic         dec_valid;
   stat_t        stat_word;

   dec_if dif ();

   function automatic logic [7:0] status_code(ifm_t m, logic off, logic gk, logic ch);
      logic [7:0] c;
      c = 8'h00;
      case (m)
         // RULE_04 serial line status
         IFM_SERIAL: c = !off ? SER_ON : (gk ? SER_GK : SER_OFF);
         // RULE_10 first variant status
         IFM_PAR1: c = !off ? P1_ON : (gk ? P1_GK : P1_OFF);
         // RULE_12 second variant status
         IFM_PAR2: c = !off ? P2_ON : (gk ? P2_GK : P2_OFF);
         // RULE_15 module board status
         IFM_MODULE: c = (!off ? MB_ON : (gk ? MB_GK : MB_OFF)) | (ch ? MB_CHB : 8'h00);
         default: c = 8'h00;
      endcase
      return c;
   endfunction

   assign ser     = s.ctrl.ifm == IFM_SERIAL;
   assign setup   = psel && !penable;
   assign wr_fire = psel && penable && s.pready && pwrite;

   // RULE_17 clock source select
   assign bit_en = s.ctrl.ext_clk ? (ext_data_clk && !s.clk_q) : (s.div == BIT_DIV_LAST);

   // RULE_07 line one to circuit B
   assign dec_code  = ser ? rx_byte : s.cmd.code;
   assign dec_chan  = ser ? s.ctrl.line_interface_circuit_sel : s.cmd.chan;
   assign dec_valid = ser ? rx_valid : s.cmd_go;

   assign stat_word = '{sts_b: s.sts[1], sts_a: s.sts[0], gk: ground_key, off: off_hook,
                        mode_b: s.mode[1], mode_a: s.mode[0]};

   // RULE_08 serial signaling byte
   sig_shifter u_shifter (
      .clock      (clock),
      .rst_n      (rst_n),
      .enable     (ser),
      .frame_sync (frame_sync),
      .cs         (!s.cs_n),
      .bit_en     (bit_en),
      .sdi        (serial_in),
      .tx_byte    (s.sts[s.ctrl.line_interface_circuit_sel]),
      .rx_byte    (rx_byte),
      .rx_valid   (rx_valid),
      .sdo        (serial_out)
   );

   mode_decoder u_decoder (
      .clock (clock),
      .rst_n (rst_n),
      .ifm   (s.ctrl.ifm),
      .code  (dec_code),
      .chan  (dec_chan),
      .valid (dec_valid),
      .dout  (dif)
   );

   always_comb begin
      n = s;
      n.cmd_go = 1'b0;
      // The slave answers in the first access cycle; pready is set during setup.
      n.pready = setup;
      n.pslverr = 1'b0;
      if (setup) begin
         n.prdata = 32'h0000_0000;
         case (paddr)
            OFF_CTRL: n.prdata = 32'(s.ctrl);
            OFF_CMD:  n.prdata = 32'(s.cmd);
            OFF_STAT: n.prdata = 32'(stat_word);
            default:  n.pslverr = 1'b1;
         endcase
      end
      if (wr_fire) begin
         case (paddr)
            OFF_CTRL: n.ctrl = ctrl_t'(pwdata[$bits(ctrl_t)-1:0]);
            OFF_CMD: begin
               n.cmd = cmd_t'(pwdata[$bits(cmd_t)-1:0]);
               // Parallel codes only; in serial mode the port byte is the sole source.
               n.cmd_go = !ser;
            end
            default: n.cmd_go = 1'b0;
         endcase
      end
      n.clk_q = ext_data_clk;
      n.div = (s.div == BIT_DIV_LAST) ? 5'h00 : s.div + 5'h01;
      // RULE_05 chip select from strobe
      n.cs_n = !(ser && signaling_strobe_pin);
      // RULE_18 ignore unknown codes
      if (dif.valid && dif.dec.hit) begin
         n.mode[dif.dec.chan] = dif.dec.mode;
         if (dif.dec.set_ilim) begin
            n.ilim[dif.dec.chan] = dif.dec.ilim;
         end
      end
      for (int i = 0; i < 2; i++) begin
         n.sts[i] = status_code(s.ctrl.ifm, off_hook[i], ground_key[i], i[0]);
         n.pdown[i] = n.mode[i] == LM_PDOWN;
         n.ring[i] = n.mode[i] == LM_RING;
         n.active[i] = n.mode[i] == LM_ACTIVE;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= ST_RST;
      end else begin
         s <= n;
      end
   end

   assign prdata    = s.prdata;
   assign pready    = s.pready;
   assign pslverr   = s.pslverr;
   assign line_cs_n = s.cs_n;
   assign pdown     = s.pdown;
   assign ring      = s.ring;
   assign active    = s.active;
   assign ilim      = s.ilim;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   AST_SER_PDOWN: assert property ( // RULE_01
      ser && rx_valid && rx_byte == SER_PDOWN && !s.ctrl.line_interface_circuit_sel |-> ##2 pdown[0])
      else $error("Serial power-down code did not power down circuit A.");

   AST_SER_ILIM: assert property ( // RULE_02
      ser && rx_valid && (rx_byte & SER_PUP_MASK) == SER_PUP_BASE && !s.ctrl.line_interface_circuit_sel
      |-> ##2 (ilim[0] == $past(rx_byte[1:0], 2)) && !pdown[0] && !ring[0])
      else $error("Serial power-up code did not set the loop current.");

   AST_SER_ACTIVE: assert property ( // RULE_03
      ser && rx_valid && rx_byte == SER_ACTIVE && !s.ctrl.line_interface_circuit_sel |-> ##2 active[0] && !ring[0])
      else $error("Serial conversation code did not select conversation.");

   AST_SER_STATUS: assert property ( // RULE_04
      ser && off_hook[0] && ground_key[0] |=> s.sts[0] == SER_GK)
      else $error("Serial ground-key status byte is wrong.");

   AST_CS_STROBE: assert property ( // RULE_05
      ser |=> line_cs_n == !$past(signaling_strobe_pin))
      else $error("Chip select does not follow the strobe.");

   AST_LINE1_B: assert property ( // RULE_07
      ser && rx_valid && s.ctrl.line_interface_circuit_sel && rx_byte == SER_RING |-> ##2 ring[1] && $stable(s.mode[0]))
      else $error("Line-one ring code did not reach circuit B alone.");

   AST_SER_ONLY: assert property ( // RULE_08
      rx_valid |-> $past(ser))
      else $error("Serial byte taken outside serial mode.");

   AST_P1_RING: assert property ( // RULE_09
      s.cmd_go && s.ctrl.ifm == IFM_PAR1 && s.cmd.code == P1_RING && !s.cmd.chan |-> ##2 ring[0])
      else $error("First variant ring code did not ring circuit A.");

   AST_P2_STATUS: assert property ( // RULE_12
      s.ctrl.ifm == IFM_PAR2 && !off_hook[1] |=> s.sts[1] == P2_ON)
      else $error("Second variant on-hook status is wrong.");

   AST_MB_CHB: assert property ( // RULE_14
      s.cmd_go && s.ctrl.ifm == IFM_MODULE && s.cmd.code == (MB_ACTIVE | MB_CHB)
      |-> ##2 active[1] && $stable(s.mode[0]))
      else $error("Channel B conversation code did not reach circuit B.");

   AST_UNKNOWN: assert property ( // RULE_18
      dif.valid && !dif.dec.hit |-> ##2 $stable(s.mode) && $stable(s.ilim))
      else $error("Unknown code changed the circuit mode.");

   COV_SER_BYTE: cover property (ser && rx_valid);
   COV_RING_A:   cover property ($rose(ring[0]));
   COV_MB_CMD:   cover property (s.cmd_go && s.ctrl.ifm == IFM_MODULE);

endmodule // line_interface_circuit_mode_signaling_decoder

/* codec_port_model.sv */
// Far side of the serial signaling port: frames, strobes and clocks one byte.
module codec_port_model import line_interface_circuit_pkg::*; (
   input  wire logic clock,
   input  wire logic serial_out,
   input  wire logic line_cs_n,
   output logic      frame_sync,
   output logic      strobe,
   output logic      ext_clk,
   output logic      sdata
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      frame_sync = 1'b0;
      strobe     = 1'b0;
      ext_clk    = 1'b0;
      sdata      = 1'b0;
   end

   task automatic wait_cy(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic send_byte(input logic [7:0] b, input logic int_clk, output logic [7:0] got,
                            output logic cs);
      frame_sync <= 1'b1;
      wait_cy(1);
      frame_sync <= 1'b0;
      strobe <= 1'b1;
      sdata  <= b[7];
      wait_cy(3);
      for (int i = 7; i >= 0; i--) begin
         got[i] = serial_out;
         if (i == 4) cs = line_cs_n;
         if (int_clk) begin
            // The board's divider fires once per bit period at an unknown phase,
            // so each bit is held for one whole period and sampled one edge into the next.
            wait_cy(int'(BIT_DIV) - 1);
            if (i > 0) sdata <= b[i-1];
            wait_cy(1);
         end else begin
            sdata <= b[i];
            wait_cy(2);
            ext_clk <= 1'b1;
            wait_cy(4);
            ext_clk <= 1'b0;
            wait_cy(2);
         end
      end
      wait_cy(4);
      strobe <= 1'b0;
      // A released line shows the inverse so a stale bit is never read as data.
      sdata <= ~b[0];
      wait_cy(1);
   endtask
endmodule // codec_port_model

/* tb_top.sv */
module tb_top import line_interface_circuit_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   logic             clock;
   logic             rst_n;
   logic             psel;
   logic             penable;
   logic             pwrite;
   logic [7:0]       paddr;
   logic [31:0]      pwdata;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic             frame_sync;
   logic             strobe;
   logic             ext_clk;
   logic             sdata;
   logic             serial_out;
   logic             line_cs_n;
   logic [1:0]       off_hook;
   logic [1:0]       ground_key;
   logic [1:0]       pdown;
   logic [1:0]       ring;
   logic [1:0]       active;
   logic [1:0][1:0]  ilim;
   int               failures = 0;
   int               check_count = 0;
   int               cyc = 0;
   logic             int_clk = 1'b0;
   localparam logic [2:0] PD = 3'b100, RG = 3'b010, AC = 3'b001, SB = 3'b000;

   line_interface_circuit_mode_signaling_decoder i_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_sync(frame_sync), .signaling_strobe_pin(strobe), .ext_data_clk(ext_clk), .serial_in(sdata),
      .serial_out(serial_out), .line_cs_n(line_cs_n), .off_hook(off_hook), .ground_key(ground_key),
      .pdown(pdown), .ring(ring), .active(active), .ilim(ilim));
   codec_port_model i_codec (.clock(clock), .serial_out(serial_out), .line_cs_n(line_cs_n),
      .frame_sync(frame_sync), .strobe(strobe), .ext_clk(ext_clk), .sdata(sdata));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task stop_test;
      if (failures == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   always @(posedge clock) begin
      cyc++;
      if (cyc == 60000) begin
         failures++;
         $display("[ERR] %0t timeout", $time);
         stop_test;
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task chk_mode(input int ch, input logic [2:0] exp);
      chk({29'h0, pdown[ch], ring[ch], active[ch]}, {29'h0, exp});
   endtask

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
            output logic err);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clock);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
      chk({31'h0, e}, 32'h0);
   endtask

   task set_line(input logic [1:0] oh, input logic [1:0] gk);
      off_hook <= oh; ground_key <= gk;
      repeat (3) @(posedge clock);
   endtask

   task ser(input logic [7:0] code, input logic [7:0] sts);
      logic [7:0] got;
      logic       cs;
      i_codec.send_byte(code, int_clk, got, cs);
      repeat (4) @(posedge clock);
      chk({24'h0, got}, {24'h0, sts});
      chk({31'h0, cs}, 32'h0);
      chk({31'h0, line_cs_n}, 32'h1);
   endtask

   task stat_chk(input logic [7:0] ea, input logic [7:0] eb);
      logic [31:0] q;
      logic        e;
      apb(1'b0, OFF_STAT, 32'h0, q, e);
      chk({16'h0, q[23:8]}, {16'h0, eb, ea});
   endtask

   task par(input logic [8:0] cmd, input int ch, input logic [2:0] exp);
      wr(OFF_CMD, {23'h0, cmd});
      repeat (5) @(posedge clock);
      chk_mode(ch, exp);
   endtask

   task t_reset_and_refusal;
      logic [31:0] q;
      logic        e;
      chk_mode(0, PD);
      chk_mode(1, PD);
      chk({30'h0, ilim[0]}, 32'h0);
      chk({31'h0, line_cs_n}, 32'h1);
      apb(1'b0, OFF_CTRL, 32'h0, q, e);
      chk(q, 32'h0);
      apb(1'b0, 8'h0C, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      par(9'h0C0, 0, PD);
   endtask

   task t_serial_a;
      logic [7:0] codes [8] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hC0, 8'hA0, 8'h55, 8'h00};
      logic [2:0] modes [8] = '{SB, SB, SB, SB, AC, RG, RG, PD};
      logic [1:0] lims  [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};
      wr(OFF_CTRL, 32'h0000_0008);
      for (int i = 0; i < 8; i++) begin
         ser(codes[i], 8'h40);
         chk_mode(0, modes[i]);
         chk({30'h0, ilim[0]}, {30'h0, lims[i]});
      end
      set_line(2'b01, 2'b00);
      ser(8'hC0, 8'hC0);
      set_line(2'b01, 2'b01);
      ser(8'h00, 8'h80);
      chk_mode(1, PD);
   endtask

   task t_serial_b;
      wr(OFF_CTRL, 32'h0000_000C);
      set_line(2'b10, 2'b00);
      ser(8'hC0, 8'hC0);
      chk_mode(1, AC);
      chk_mode(0, PD);
      int_clk = 1'b1;
      wr(OFF_CTRL, 32'h0000_0004);
      ser(8'hA0, 8'hC0);
      chk_mode(1, RG);
      chk_mode(0, PD);
      int_clk = 1'b0;
   endtask

   task t_par1;
      wr(OFF_CTRL, 32'h0000_0001);
      par(9'h080, 0, AC);
      par(9'h0E0, 0, RG);
      par(9'h0C0, 0, RG);
      par(9'h000, 0, PD);
      set_line(2'b00, 2'b00);
      stat_chk(8'h80, 8'h80);
      set_line(2'b11, 2'b00);
      stat_chk(8'h00, 8'h00);
      set_line(2'b11, 2'b11);
      stat_chk(8'h40, 8'h40);
   endtask

   task t_par2;
      wr(OFF_CTRL, 32'h0000_0002);
      par(9'h111, 1, AC);
      par(9'h177, 1, RG);
      par(9'h100, 1, PD);
      stat_chk(8'h22, 8'h22);
      set_line(2'b11, 2'b00);
      stat_chk(8'h00, 8'h00);
      set_line(2'b00, 2'b00);
      stat_chk(8'h11, 8'h11);
   endtask

   task t_module;
      wr(OFF_CTRL, 32'h0000_0003);
      par(9'h003, 0, SB);
      par(9'h007, 0, AC);
      par(9'h04F, 0, RG);
      par(9'h087, 1, AC);
      par(9'h0CF, 1, RG);
      par(9'h083, 1, SB);
      chk_mode(0, RG);
      set_line(2'b11, 2'b00);
      stat_chk(8'h03, 8'h83);
      set_line(2'b11, 2'b11);
      stat_chk(8'h4B, 8'hCB);
      set_line(2'b00, 2'b00);
      stat_chk(8'h01, 8'h81);
   endtask

   initial begin
      rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; off_hook = 2'b00; ground_key = 2'b00;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_reset_and_refusal;
      t_serial_a;
      t_serial_b;
      t_par1;
      t_par2;
      t_module;
      stop_test;
   end
endmodule // tb_top
